// File: logic/gstk_core.sv
// module: register bank addressing, stack pointer and limit traps
//
// Function
// - short 4-bit operand added to bank base, doubled for words, plain for bytes.
// - pointer registers read as words; 2-bit operand picks first four.
// - 8-bit operand F0..FF uses low nibble as bank index.
// - bit operations use register word address plus separate 4-bit position.
// - stack pointer decremented before push, incremented after pop.
// - stack pointer bit 0 zero, bits 15..12 one, always.
// - a stack pointer register write updates stack pointer; no pop right after it. Such a pop still steps the pointer and sets pop_hazard_out.
// - push or subtraction leaving pointer below low limit raises overflow trap.
// - pop or addition leaving pointer above high limit raises underflow trap.
// - low limit bit 0 zero, bits 15..12 one.
// - high limit bit 0 zero, bits 15..12 one.
// - direct moves and limit changes never raise a limit trap.
module gstk_core (
	input  wire logic                 sys_clk_in,
	input  wire logic                 rst_in,
	input  wire logic [15:0]          bank_base_in,
	input  wire gstk_pkg::gstk_areq_s areq_in,
	input  wire gstk_pkg::gstk_sop_s  sop_in,
	input  wire gstk_pkg::gstk_rwr_s  rwr_in,
	input  wire logic [15:0]          rd_addr_in,
	output logic      [15:0]          gpr_addr_out,
	output logic                      gpr_is_bank_out,
	output logic      [15:0]          gpr_bit_mask_out,
	output logic      [15:0]          push_addr_out,
	output logic      [15:0]          stack_top_pointer_out,
	output logic      [15:0]          rd_data_out,
	output logic                      overflow_trap_out,
	output logic                      underflow_trap_out,
	output logic                      pop_hazard_out
);
	import gstk_pkg::*;

	logic [15:0] stack_top_pointer;
	logic [15:0] stack_low_limit;
	logic [15:0] stack_high_limit;
	logic        sp_written;
	logic        check_low;
	logic        check_high;
	logic [15:0] gpr_addr;
	logic        gpr_is_bank;
	logic [15:0] gpr_bit_mask;

	// address former
	gstk_gpr_addr u_addr (
		.bank_base_in (bank_base_in),
		.req_in       (areq_in),
		.addr_out     (gpr_addr),
		.is_bank_out  (gpr_is_bank),
		.bit_mask_out (gpr_bit_mask)
	);

	// register write decode
	wire logic wr_sp   = rwr_in.wr && (rwr_in.addr == GSTK_SP_OFS);
	wire logic wr_low  = rwr_in.wr && (rwr_in.addr == GSTK_LOW_OFS);
	wire logic wr_high = rwr_in.wr && (rwr_in.addr == GSTK_HIGH_OFS);

	// stack pointer next value; push pre-decrements, pop post-increments
	wire logic [15:0] sp_dec  = stack_top_pointer - GSTK_WORD_STEP;
	wire logic [15:0] sp_inc  = stack_top_pointer + GSTK_WORD_STEP;
	wire logic [15:0] sp_sub  = stack_top_pointer - sop_in.amount;
	wire logic [15:0] sp_add  = stack_top_pointer + sop_in.amount;
	wire logic        down_op = sop_in.push || sop_in.sub;
	wire logic        up_op   = sop_in.pop || sop_in.add;
	wire logic [15:0] next_sp =
		wr_sp        ? gstk_fix(rwr_in.data) :
		sop_in.push  ? gstk_fix(sp_dec) :
		sop_in.pop   ? gstk_fix(sp_inc) :
		sop_in.sub   ? gstk_fix(sp_sub) :
		sop_in.add   ? gstk_fix(sp_add) : stack_top_pointer;
	wire logic        next_check_low  = down_op && !wr_sp;
	wire logic        next_check_high = up_op && !wr_sp;

	// read mux, unmapped reads give zero
	wire logic [15:0] next_rd =
		(rd_addr_in == GSTK_SP_OFS)   ? stack_top_pointer :
		(rd_addr_in == GSTK_LOW_OFS)  ? stack_low_limit :
		(rd_addr_in == GSTK_HIGH_OFS) ? stack_high_limit : 16'h0000;

	// limit compares on the pointer settled one edge after its update
	wire logic ovf_hit = stack_top_pointer < stack_low_limit;
	wire logic unf_hit = stack_top_pointer > stack_high_limit;

	// stack pointer; a direct write beats any stack operation
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			stack_top_pointer <= GSTK_SP_RST;
		end else begin
			stack_top_pointer <= next_sp;
		end
	end

	// low limit, fixed bits forced on write
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			stack_low_limit <= GSTK_LOW_RST;
		end else if (wr_low) begin
			stack_low_limit <= gstk_fix(rwr_in.data);
		end
	end

	// high limit, fixed bits forced on write
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			stack_high_limit <= GSTK_HIGH_RST;
		end else if (wr_high) begin
			stack_high_limit <= gstk_fix(rwr_in.data);
		end
	end

	// overflow compare pending after push or subtraction
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			check_low <= 1'b0;
		end else begin
			check_low <= next_check_low;
		end
	end

	// underflow compare pending after pop or addition
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			check_high <= 1'b0;
		end else begin
			check_high <= next_check_high;
		end
	end

	// marks a pointer write, for the pop hazard
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sp_written <= 1'b0;
		end else begin
			sp_written <= wr_sp;
		end
	end

	// overflow request, one cycle, updated pointer only
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			overflow_trap_out <= 1'b0;
		end else begin
			overflow_trap_out <= check_low && ovf_hit;
		end
	end

	// underflow request, one cycle, updated pointer only
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			underflow_trap_out <= 1'b0;
		end else begin
			underflow_trap_out <= check_high && unf_hit;
		end
	end

	// flags a pop right behind a pointer write
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pop_hazard_out <= 1'b0;
		end else begin
			pop_hazard_out <= sp_written && sop_in.pop;
		end
	end

	// read data, one cycle behind the address
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_data_out <= 16'h0000;
		end else begin
			rd_data_out <= next_rd;
		end
	end

	// pointer copy for the pipeline
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			stack_top_pointer_out <= GSTK_SP_RST;
		end else begin
			stack_top_pointer_out <= next_sp;
		end
	end

	// where a push would land from the pointer of the previous cycle
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			push_addr_out <= GSTK_SP_RST;
		end else begin
			push_addr_out <= gstk_fix(sp_dec);
		end
	end

	// register address, one cycle behind the request
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			gpr_addr_out <= 16'h0000;
		end else begin
			gpr_addr_out <= gpr_addr;
		end
	end

	// bank hit for 8-bit operands
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			gpr_is_bank_out <= 1'b0;
		end else begin
			gpr_is_bank_out <= gpr_is_bank;
		end
	end

	// bit select within the register word
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			gpr_bit_mask_out <= 16'h0000;
		end else begin
			gpr_bit_mask_out <= gpr_bit_mask;
		end
	end
endmodule

// File: logic/gstk_gpr_addr.sv
// module: physical register address from bank base and short operand
module gstk_gpr_addr (
	input  wire logic [15:0]         bank_base_in,
	input  wire gstk_pkg::gstk_areq_s req_in,
	output logic      [15:0]         addr_out,
	output logic                     is_bank_out,
	output logic      [15:0]         bit_mask_out
);
	import gstk_pkg::*;

	// select the 4-bit bank index
	wire logic [3:0]  idx      = (req_in.kind == GSTK_OP_SHORT2) ?
		{2'h0, req_in.operand[1:0]} : req_in.operand[3:0];
	wire logic        reg8_hit = req_in.operand[7:4] == GSTK_SHORT_HI;
	wire logic        word_acc = !req_in.byte_acc || (req_in.kind == GSTK_OP_SHORT2);
	wire logic [15:0] ofs      = word_acc ? {11'h000, idx, 1'b0} : {12'h000, idx};

	// bank-relative address and bit select
	assign addr_out     = bank_base_in + ofs;
	assign is_bank_out  = (req_in.kind != GSTK_OP_REG8) || reg8_hit;
	assign bit_mask_out = 16'h0001 << req_in.bit_pos;
endmodule

// File: logic/gstk_pkg.sv
// package: constants and carriers for register addressing and stack limits
package gstk_pkg;
	localparam int          GSTK_W          = 16;
	localparam logic [15:0] GSTK_LOW_OFS    = 16'hFE14;
	localparam logic [15:0] GSTK_HIGH_OFS   = 16'hFE16;
	localparam logic [15:0] GSTK_SP_OFS     = 16'hFE12;
	localparam logic [15:0] GSTK_LOW_RST    = 16'hFA00;
	localparam logic [15:0] GSTK_HIGH_RST   = 16'hFC00;
	localparam logic [15:0] GSTK_SP_RST     = 16'hFC00;
	localparam logic [15:0] GSTK_FIX_ONES   = 16'hF000;
	localparam logic [15:0] GSTK_FIX_MASK   = 16'h0FFE;
	localparam logic [3:0]  GSTK_SHORT_HI   = 4'hF;
	localparam logic [15:0] GSTK_WORD_STEP  = 16'h0002;

	// operand kinds handed in by the pipeline
	typedef enum logic [1:0] {
		GSTK_OP_SHORT4,
		GSTK_OP_SHORT2,
		GSTK_OP_REG8
	} gstk_opkind_e;

	// address request from the pipeline
	typedef struct packed {
		gstk_opkind_e kind;
		logic         byte_acc;
		logic [7:0]   operand;
		logic [3:0]   bit_pos;
	} gstk_areq_s;

	// stack operation from the pipeline
	typedef struct packed {
		logic        push;
		logic        pop;
		logic        add;
		logic        sub;
		logic [15:0] amount;
	} gstk_sop_s;

	// register write port
	typedef struct packed {
		logic        wr;
		logic [15:0] addr;
		logic [15:0] data;
	} gstk_rwr_s;

	// fix bit 0 low and bits 15..12 high
	function automatic logic [15:0] gstk_fix(input logic [15:0] v);
		return (v & GSTK_FIX_MASK) | GSTK_FIX_ONES;
	endfunction
endpackage

// File: testbench/gstk_core_sva.sv
// checker: addressing, stack pointer and trap assertions
module gstk_core_sva
	import gstk_pkg::*;
(
	input wire logic        sys_clk_in,
	input wire logic        rst_in,
	input wire logic [15:0] bank_base_in,
	input wire gstk_areq_s  areq_in,
	input wire gstk_sop_s   sop_in,
	input wire gstk_rwr_s   rwr_in,
	input wire logic [15:0] rd_addr_in,
	input wire logic [15:0] gpr_addr_out,
	input wire logic [15:0] gpr_bit_mask_out,
	input wire logic [15:0] stack_top_pointer_out,
	input wire logic [15:0] push_addr_out,
	input wire logic [15:0] rd_data_out,
	input wire logic        overflow_trap_out,
	input wire logic        underflow_trap_out,
	input wire logic        pop_hazard_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	// limit write, then read back of the same place
	wire lim_wr = rwr_in.wr && (rwr_in.addr == GSTK_LOW_OFS || rwr_in.addr == GSTK_HIGH_OFS);
	// bank index as the rules pick it: two bits for pointer operands
	wire logic [3:0] exp_idx = (areq_in.kind == GSTK_OP_SHORT2) ?
		{2'h0, areq_in.operand[1:0]} : areq_in.operand[3:0];
	sequence s_lim_rd;
		lim_wr ##1 !rwr_in.wr ##1 (rd_addr_in == $past(rwr_in.addr, 2) && !rwr_in.wr);
	endsequence
	sequence s_sp_pop;
		(rwr_in.wr && rwr_in.addr == GSTK_SP_OFS) ##1 sop_in.pop;
	endsequence
	a_sp_fixed_bits: assert property ((stack_top_pointer_out & 16'hF001) == 16'hF000)
		else $error("pointer fixed bits wrong");
	a_push_pre_dec: assert property (!rst_in && sop_in.push && !rwr_in.wr |=>
		stack_top_pointer_out ==
		((($past(stack_top_pointer_out) - 16'h0002) & GSTK_FIX_MASK) | GSTK_FIX_ONES))
		else $error("push step wrong");
	a_pop_post_inc: assert property (!rst_in && sop_in.pop && !rwr_in.wr |=>
		stack_top_pointer_out ==
		((($past(stack_top_pointer_out) + 16'h0002) & GSTK_FIX_MASK) | GSTK_FIX_ONES))
		else $error("pop step wrong");
	a_short_gpr_addr: assert property (!rst_in && (areq_in.kind != GSTK_OP_REG8 ||
		areq_in.operand[7:4] == GSTK_SHORT_HI) |=> gpr_addr_out == $past(bank_base_in) +
		(16'($past(exp_idx)) << !$past(areq_in.byte_acc && areq_in.kind != GSTK_OP_SHORT2)))
		else $error("register address wrong");
	a_bit_mask_pos: assert property (!rst_in |=>
		gpr_bit_mask_out == 16'h0001 << $past(areq_in.bit_pos))
		else $error("bit mask wrong");
	a_push_addr_step: assert property (!rst_in |=> push_addr_out ==
		((($past(stack_top_pointer_out) - 16'h0002) & GSTK_FIX_MASK) | GSTK_FIX_ONES))
		else $error("push address wrong");
	a_limit_fixed_rd: assert property (s_lim_rd |=>
		rd_data_out == (($past(rwr_in.data, 3) & GSTK_FIX_MASK) | GSTK_FIX_ONES))
		else $error("limit read back wrong");
	a_ovf_trap_cause: assert property (overflow_trap_out |-> $past(sop_in.push || sop_in.sub, 2))
		else $error("overflow trap without push or subtract");
	a_unf_trap_cause: assert property (underflow_trap_out |-> $past(sop_in.pop || sop_in.add, 2))
		else $error("underflow trap without pop or add");
	a_pop_hazard_flag: assert property (s_sp_pop |-> ##[1:2] pop_hazard_out)
		else $error("pop after pointer write not flagged");
endmodule
bind gstk_core gstk_core_sva u_gstk_core_sva (.*);

// File: testbench/gstk_core_test.sv
// bench: addressing table, register access and stack traps
module gstk_core_test;
	timeunit 1ns;
	timeprecision 1ps;
	import gstk_pkg::*;
	typedef struct {gstk_areq_s r; logic [15:0] a; logic b;} gstk_row_s;
	logic        sys_clk_in = 1'b0, rst_in = 1'b1, gpr_is_bank_out, overflow_trap_out;
	logic        underflow_trap_out, pop_hazard_out;
	logic [15:0] bank_base_in = 16'hFC00, rd_addr_in = 16'h0000, gpr_addr_out, gpr_bit_mask_out;
	logic [15:0] push_addr_out, stack_top_pointer_out, rd_data_out;
	logic [7:0]  ovf_cnt, unf_cnt;
	gstk_areq_s  areq_in = '0;
	gstk_sop_s   sop_in = '0;
	gstk_rwr_s   rwr_in = '0;
	int          miscompares = 0, comparisons = 0;
	gstk_row_s   rows[5] = '{'{'{GSTK_OP_SHORT4, 1'b0, 8'h03, 4'h0}, 16'hFC06, 1'b1},
		'{'{GSTK_OP_SHORT4, 1'b1, 8'h0F, 4'h5}, 16'hFC0F, 1'b1},
		'{'{GSTK_OP_SHORT2, 1'b1, 8'h03, 4'h9}, 16'hFC06, 1'b1},
		'{'{GSTK_OP_REG8, 1'b0, 8'hF5, 4'hF}, 16'hFC0A, 1'b1},
		'{'{GSTK_OP_REG8, 1'b0, 8'h35, 4'h1}, 16'h0000, 1'b0}};
	gstk_core u_gstk_core (.*);
	gstk_trap_model u_gstk_trap_model (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
		.ovf_in(overflow_trap_out), .unf_in(underflow_trap_out),
		.ovf_cnt_out(ovf_cnt), .unf_cnt_out(unf_cnt));
	initial forever #5 sys_clk_in = ~sys_clk_in;
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge sys_clk_in) rwr_in <= '{1'b1, a, d};
		@(posedge sys_clk_in) rwr_in <= '0;
	endtask
	task rd(input logic [15:0] a, input logic [15:0] exp);
		@(posedge sys_clk_in) rd_addr_in <= a;
		@(posedge sys_clk_in) #1 chk(rd_data_out, exp);
	endtask
	task op(input logic [3:0] k, input logic [15:0] amt, input logic [15:0] exp_sp);
		@(posedge sys_clk_in) sop_in <= '{k[3], k[2], k[1], k[0], amt};
		@(posedge sys_clk_in) sop_in <= '0;
		#1 chk(stack_top_pointer_out, exp_sp);
	endtask
	task finish_test;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#30us miscompares++;
		finish_test;
	end
	initial begin
		repeat (12) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		rd(GSTK_LOW_OFS, 16'hFA00);
		rd(GSTK_HIGH_OFS, 16'hFC00);
		rd(GSTK_SP_OFS, 16'hFC00);
		rd(16'h0000, 16'h0000);
		$display("done: reset values");
		foreach (rows[i]) begin
			@(posedge sys_clk_in) areq_in <= rows[i].r;
			@(posedge sys_clk_in) #1 chk(16'(gpr_is_bank_out), 16'(rows[i].b));
			if (rows[i].b) chk(gpr_addr_out, rows[i].a);
			chk(gpr_bit_mask_out, 16'h0001 << rows[i].r.bit_pos);
		end
		@(posedge sys_clk_in) begin
			bank_base_in <= 16'hFD10;
			areq_in      <= rows[3].r;
		end
		@(posedge sys_clk_in) #1 chk(gpr_addr_out, 16'hFD1A);
		$display("done: addressing");
		wr(GSTK_SP_OFS, 16'h0FFF);
		rd(GSTK_SP_OFS, 16'hFFFE);
		wr(GSTK_HIGH_OFS, 16'h0001);
		rd(GSTK_HIGH_OFS, 16'hF000);
		wr(GSTK_LOW_OFS, 16'hFBF0 + 16'h000C);
		wr(GSTK_HIGH_OFS, 16'hFC00);
		wr(GSTK_SP_OFS, 16'hFC00);
		rd(GSTK_LOW_OFS, 16'hFBFC);
		op(4'h8, 16'h0000, 16'hFBFE);
		op(4'h8, 16'h0000, 16'hFBFC);
		op(4'h8, 16'h0000, 16'hFBFA);
		repeat (2) @(posedge sys_clk_in);
		repeat (4) @(posedge sys_clk_in) #1 chk(16'(ovf_cnt), 16'h0001);
		op(4'h4, 16'h0000, 16'hFBFC);
		op(4'h4, 16'h0000, 16'hFBFE);
		op(4'h4, 16'h0000, 16'hFC00);
		op(4'h4, 16'h0000, 16'hFC02);
		wr(GSTK_SP_OFS, 16'hF000);
		op(4'h2, 16'h0C02, 16'hFC02);
		op(4'h1, 16'h0008, 16'hFBFA);
		repeat (2) @(posedge sys_clk_in);
		repeat (4) @(posedge sys_clk_in) #1 chk(16'({ovf_cnt, unf_cnt}), 16'h0202);
		$display("done: stack traps");
		@(posedge sys_clk_in) rwr_in <= '{1'b1, GSTK_SP_OFS, 16'hF002};
		@(posedge sys_clk_in) rwr_in <= '0;
		sop_in <= '{1'b0, 1'b1, 1'b0, 1'b0, 16'h0000};
		@(posedge sys_clk_in) sop_in <= '0;
		#1 chk(stack_top_pointer_out, 16'hF004);
		chk(16'(pop_hazard_out), 16'h0001);
		chk(push_addr_out, 16'hF000);
		$display("done: pop after write");
		finish_test;
	end
endmodule

// File: testbench/gstk_trap_model.sv
// partner: trap logic counting overflow and underflow requests
module gstk_trap_model (
	input  wire logic       sys_clk_in,
	input  wire logic       rst_in,
	input  wire logic       ovf_in,
	input  wire logic       unf_in,
	output logic      [7:0] ovf_cnt_out,
	output logic      [7:0] unf_cnt_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// every high cycle is taken as one more trap request
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ovf_cnt_out <= 8'h00;
			unf_cnt_out <= 8'h00;
		end else begin
			ovf_cnt_out <= ovf_cnt_out + 8'(ovf_in);
			unf_cnt_out <= unf_cnt_out + 8'(unf_in);
		end
	end
endmodule
